// file: core/rtcalm_cfg.svh
// Purpose: Register offsets, field positions and widths of the alarm regs.
// Assumes: Word-indexed plain register port, 16-bit data.
// Notes:   Definitions only; no logic.
`ifndef RTCALM_CFG_SVH
`define RTCALM_CFG_SVH

// ************************************************************
// Register offsets
// ************************************************************
`define RTCALM_ADDR_W          4
`define RTCALM_OFF_WDHR        4'h0
`define RTCALM_OFF_MINSEC      4'h1
`define RTCALM_OFF_UNLOCK      4'h2

// ************************************************************
// Field positions
// ************************************************************
`define RTCALM_ALARM_WEEKDAY_DIGIT_LSB        8
`define RTCALM_HRTENS_LSB      4
`define RTCALM_HRONES_LSB      0
`define RTCALM_MINTENS_LSB     12
`define RTCALM_MINONES_LSB     8
`define RTCALM_SECTENS_LSB     4
`define RTCALM_SECONES_LSB     0
`define RTCALM_UNLOCK_BIT      0

// ************************************************************
// Implemented-bit masks and reset values
// ************************************************************
`define RTCALM_WDHR_MASK       16'h073F
`define RTCALM_MINSEC_MASK     16'h7F7F
`define RTCALM_UNLOCK_RST      1'h0

`endif

// file: core/rtcalm_field.sv
// Purpose: One write-gated digit field holding register.
// Assumes: Clock enable and write qualifier come from the parent.
// Notes:   No reset: value is unknown until first write.
`timescale 1ns/10ps
`default_nettype none
module rtcalm_field #(
	parameter int W = 4                   // Field width
) (
	input  wire logic         clock,      // 25 MHz clock
	input  wire logic         ce,         // Clock enable
	input  wire logic         we,         // Qualified write
	input  wire logic [W-1:0] d,          // New digit
	output var  logic [W-1:0] q           // Stored digit
);

	// ************************************************************
	// Storage
	// ************************************************************
	// Deliberately unreset, matching power-on unknown digits
	always_ff @(posedge clock) begin
		if (ce && we) begin
			q <= d;
		end
	end

endmodule : rtcalm_field
`default_nettype wire

// file: core/rtcalm_pkg.sv
// Purpose: Types shared by the alarm value register block.
// Assumes: Constants live in rtcalm_cfg.svh.
// Notes:   Field layouts follow the register bit map.
package rtcalm_pkg;

	// ************************************************************
	// Alarm time as presented to the comparator
	// ************************************************************
	typedef struct packed {
		logic [2:0] weekday;       // 0..6
		logic [1:0] hour_tens;     // 0..2
		logic [3:0] hour_ones;     // 0..9
		logic [2:0] minute_tens;   // 0..5
		logic [3:0] minute_ones;   // 0..9
		logic [2:0] second_tens;   // 0..5
		logic [3:0] second_ones;   // 0..9
	} rtcalm_time_s;

	// Register port request
	typedef struct packed {
		logic [3:0]  addr;         // Word index
		logic [15:0] wdata;        // Write data
		logic        wr;           // Write strobe
		logic        rd;           // Read strobe
	} rtcalm_req_s;

endpackage : rtcalm_pkg

// file: core/rtcalm_regs.sv
// Purpose: Alarm weekday/hours and minutes/seconds value registers.
// Assumes: Plain register port; read data one cycle after read strobe.
// Notes:   Digit fields carry no reset; only the unlock bit and the read data reset.
`timescale 1ns/10ps
`default_nettype none
`include "rtcalm_cfg.svh"
module rtcalm_regs
	import rtcalm_pkg::*;
(
	input  wire logic         clock,          // 25 MHz clock
	input  wire logic         rst,            // Sync reset, active high
	input  wire logic         ce,             // Clock enable
	input  wire logic [3:0]   addr,           // Register word index
	input  wire logic [15:0]  wdata,          // Write data
	input  wire logic         wr,             // Write strobe
	input  wire logic         rd,             // Read strobe
	output var  logic [15:0]  rdata,          // Read data, cycle after rd
	output var  logic         clock_write_unlock, // Unlock state
	output var  rtcalm_time_s alarm_time      // To alarm comparator
);

	// ************************************************************
	// State and decode
	// ************************************************************
	typedef struct packed {
		logic        unlock;      // Write-unlock control
		logic [15:0] rdata;       // Registered read data
	} rtcalm_state_s;

	rtcalm_state_s st;            // Registered state
	rtcalm_state_s next_st;       // Next state
	logic          we_wdhr;       // Qualified weekday/hours write
	logic          we_minsec;     // Minutes/seconds write
	logic [15:0]   wdhr_view;     // Weekday/hours read image
	logic [15:0]   minsec_view;   // Minutes/seconds read image

	// Locked writes to weekday/hours are silently dropped
	assign we_wdhr   = wr && addr == `RTCALM_OFF_WDHR
	                   && st.unlock;
	assign we_minsec = wr && addr == `RTCALM_OFF_MINSEC;

	// ************************************************************
	// Digit fields, no reset
	// ************************************************************
	// Unreset on purpose: contents stay unknown until written
	rtcalm_field #(.W(3)) u_alarm_weekday_digit (.clock(clock), .ce(ce), .we(we_wdhr),
		.d(wdata[`RTCALM_ALARM_WEEKDAY_DIGIT_LSB +: 3]), .q(alarm_time.weekday));
	rtcalm_field #(.W(2)) u_hrt (.clock(clock), .ce(ce), .we(we_wdhr),
		.d(wdata[`RTCALM_HRTENS_LSB +: 2]), .q(alarm_time.hour_tens));
	rtcalm_field #(.W(4)) u_hro (.clock(clock), .ce(ce), .we(we_wdhr),
		.d(wdata[`RTCALM_HRONES_LSB +: 4]), .q(alarm_time.hour_ones));
	rtcalm_field #(.W(3)) u_mnt (.clock(clock), .ce(ce), .we(we_minsec),
		.d(wdata[`RTCALM_MINTENS_LSB +: 3]),
		.q(alarm_time.minute_tens));
	rtcalm_field #(.W(4)) u_mno (.clock(clock), .ce(ce), .we(we_minsec),
		.d(wdata[`RTCALM_MINONES_LSB +: 4]),
		.q(alarm_time.minute_ones));
	rtcalm_field #(.W(3)) u_sct (.clock(clock), .ce(ce), .we(we_minsec),
		.d(wdata[`RTCALM_SECTENS_LSB +: 3]),
		.q(alarm_time.second_tens));
	rtcalm_field #(.W(4)) u_sco (.clock(clock), .ce(ce), .we(we_minsec),
		.d(wdata[`RTCALM_SECONES_LSB +: 4]),
		.q(alarm_time.second_ones));

	// ************************************************************
	// Read images
	// ************************************************************
	// Unused positions are hard zero, so writes there leave no trace
	always_comb begin
		wdhr_view = 16'h0000;
		wdhr_view[`RTCALM_ALARM_WEEKDAY_DIGIT_LSB +: 3]   = alarm_time.weekday;
		wdhr_view[`RTCALM_HRTENS_LSB +: 2] = alarm_time.hour_tens;
		wdhr_view[`RTCALM_HRONES_LSB +: 4] = alarm_time.hour_ones;
		wdhr_view = wdhr_view & `RTCALM_WDHR_MASK;
		minsec_view = 16'h0000;
		minsec_view[`RTCALM_MINTENS_LSB +: 3] = alarm_time.minute_tens;
		minsec_view[`RTCALM_MINONES_LSB +: 4] = alarm_time.minute_ones;
		minsec_view[`RTCALM_SECTENS_LSB +: 3] = alarm_time.second_tens;
		minsec_view[`RTCALM_SECONES_LSB +: 4] = alarm_time.second_ones;
		minsec_view = minsec_view & `RTCALM_MINSEC_MASK;
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		next_st = st;
		// Unlock control is a plain software bit
		if (wr && addr == `RTCALM_OFF_UNLOCK) begin
			next_st.unlock = wdata[`RTCALM_UNLOCK_BIT];
		end
		// Read data lives only in the cycle after the strobe
		next_st.rdata = 16'h0000;
		if (rd) begin
			case (addr)
				`RTCALM_OFF_WDHR:   next_st.rdata = wdhr_view;
				`RTCALM_OFF_MINSEC: next_st.rdata = minsec_view;
				`RTCALM_OFF_UNLOCK: next_st.rdata = {15'h0000, st.unlock};
				default:            next_st.rdata = 16'h0000; // Unmapped
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	always_ff @(posedge clock) begin
		if (rst) begin
			st.unlock <= `RTCALM_UNLOCK_RST;
			st.rdata  <= 16'h0000;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rdata              = st.rdata;
	assign clock_write_unlock = st.unlock;   // Stored unlock bit feeds out directly

	// ************************************************************
	// Assertions
	// ************************************************************
	property p_locked_hold;
		@(posedge clock) disable iff (rst)
		(ce && wr && addr == `RTCALM_OFF_WDHR && !st.unlock)
		|=> $stable(wdhr_view);
	endproperty
	a_locked_hold: assert property (p_locked_hold)
		else $error("weekday/hours changed while locked");

	property p_wdhr_write;
		@(posedge clock) disable iff (rst)
		(ce && we_wdhr) |=> wdhr_view == ($past(wdata) & `RTCALM_WDHR_MASK);
	endproperty
	a_wdhr_write: assert property (p_wdhr_write)
		else $error("weekday/hours write not stored");

	property p_minsec_write;
		@(posedge clock) disable iff (rst)
		(ce && we_minsec)
		|=> minsec_view == ($past(wdata) & `RTCALM_MINSEC_MASK);
	endproperty
	a_minsec_write: assert property (p_minsec_write)
		else $error("minutes/seconds write not stored");

	property p_read_wdhr;
		@(posedge clock) disable iff (rst)
		(ce && rd && addr == `RTCALM_OFF_WDHR && !(wr))
		|=> rdata == $past(wdhr_view);
	endproperty
	a_read_wdhr: assert property (p_read_wdhr)
		else $error("weekday/hours read wrong");

	property p_read_minsec;
		@(posedge clock) disable iff (rst)
		(ce && rd && addr == `RTCALM_OFF_MINSEC)
		|=> rdata == $past(minsec_view);
	endproperty
	a_read_minsec: assert property (p_read_minsec)
		else $error("minutes/seconds read wrong");

	property p_zero_bits;
		@(posedge clock) disable iff (rst)
		ce && $past(ce) && $past(rd) && $past(addr) == `RTCALM_OFF_WDHR
		|-> (rdata & ~`RTCALM_WDHR_MASK) == 16'h0000;
	endproperty
	a_zero_bits: assert property (p_zero_bits)
		else $error("unused weekday/hours bit read nonzero");

	property p_idle_zero;
		@(posedge clock) disable iff (rst)
		(ce && !rd) |=> rdata == 16'h0000;
	endproperty
	a_idle_zero: assert property (p_idle_zero)
		else $error("read data not zero outside read slot");

	property p_unlock_set;
		@(posedge clock) disable iff (rst)
		(ce && wr && addr == `RTCALM_OFF_UNLOCK)
		|=> clock_write_unlock == $past(wdata[0]);
	endproperty
	a_unlock_set: assert property (p_unlock_set)
		else $error("unlock control not written");

	property p_sec_out;
		@(posedge clock) disable iff (rst)
		(ce && we_minsec) |=> alarm_time.second_tens == $past(wdata[6:4])
			&& alarm_time.second_ones == $past(wdata[3:0]);
	endproperty
	a_sec_out: assert property (p_sec_out)
		else $error("seconds not presented to comparator");

	// Weekday and hour digits must reach the comparator as written
	property p_hour_out;
		@(posedge clock) disable iff (rst)
		(ce && we_wdhr) |=> alarm_time.weekday == $past(wdata[10:8])
			&& alarm_time.hour_tens == $past(wdata[5:4])
			&& alarm_time.hour_ones == $past(wdata[3:0]);
	endproperty
	a_hour_out: assert property (p_hour_out)
		else $error("weekday/hours not presented to comparator");

	// Minute digits must reach the comparator as written
	property p_min_out;
		@(posedge clock) disable iff (rst)
		(ce && we_minsec) |=> alarm_time.minute_tens == $past(wdata[14:12])
			&& alarm_time.minute_ones == $past(wdata[11:8]);
	endproperty
	a_min_out: assert property (p_min_out)
		else $error("minutes not presented to comparator");

	c_unlocked_write: cover property (@(posedge clock) disable iff (rst)
		ce && we_wdhr);
	c_locked_write: cover property (@(posedge clock) disable iff (rst)
		ce && wr && addr == `RTCALM_OFF_WDHR && !st.unlock);
	c_read_back: cover property (@(posedge clock) disable iff (rst)
		ce && we_minsec ##1 ce && rd && addr == `RTCALM_OFF_MINSEC);

endmodule : rtcalm_regs
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the alarm value register block.
// Assumes: Sync reset, 40 ns clock, plain register port from the bench.
// Notes:   Expected values come from the register bit map, not the DUT.
`timescale 1ns/10ps
`default_nettype none
`include "rtcalm_cfg.svh"
module tb_top
	import rtcalm_pkg::*;
;
	logic         clock;              // 25 MHz clock
	logic         rst;                // Sync reset, active high
	logic         ce;                 // Clock enable
	logic [3:0]   addr;               // Register word index
	logic [15:0]  wdata;              // Write data
	logic         wr;                 // Write strobe
	logic         rd;                 // Read strobe
	logic [15:0]  rdata;              // Read data
	logic         clock_write_unlock; // Unlock state
	rtcalm_time_s alarm_time;         // Digits seen by comparator
	int           miscompares;        // Mismatch count
	int           compares;           // Comparison count
	int           cycles;             // Timeout counter

	rtcalm_regs uut (
		.clock              (clock),
		.rst                (rst),
		.ce                 (ce),
		.addr               (addr),
		.wdata              (wdata),
		.wr                 (wr),
		.rd                 (rd),
		.rdata              (rdata),
		.clock_write_unlock (clock_write_unlock),
		.alarm_time         (alarm_time)
	);

	// ************************************************************
	// Clock and hang guard
	// ************************************************************
	initial begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end

	// Whole run is under a hundred cycles; a hang stops well past it
	always @(posedge clock) begin
		cycles++;
		if (cycles == 1000) begin
			miscompares++;
			end_of_test();
		end
	end

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input string n, input logic [31:0] s,
		input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	// One-cycle write strobe; the field lands at the next edge
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr  <= a;
		wdata <= d;
		wr    <= 1'h1;
		@(posedge clock);
		wr    <= 1'h0;
		#1;
	endtask : wr_reg

	// Read data stands only the cycle after the strobe, then drops
	task automatic rd_reg(input string n, input logic [3:0] a,
		input logic [15:0] e);
		@(posedge clock);
		addr <= a;
		rd   <= 1'h1;
		@(posedge clock);
		rd   <= 1'h0;
		#1 chk(n, rdata, e);
		@(posedge clock);
		#1 chk("rdata_idle", rdata, 16'h0000);
	endtask : rd_reg

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test

	// ************************************************************
	// Scenarios
	// ************************************************************
	// Lock gate on the weekday/hours register
	task automatic t_lock();
		chk("digits_unreset", {9'h000, alarm_time}, {9'h000, {23{1'bx}}});
		chk("unlock_rst", clock_write_unlock, 1'h0);
		wr_reg(`RTCALM_OFF_UNLOCK, 16'h0001);
		chk("unlock_set", clock_write_unlock, 1'h1);
		wr_reg(`RTCALM_OFF_WDHR, 16'h0629);
		chk("weekday", alarm_time.weekday, 3'h6);
		chk("hour_tens", alarm_time.hour_tens, 2'h2);
		chk("hour_ones", alarm_time.hour_ones, 4'h9);
		wr_reg(`RTCALM_OFF_UNLOCK, 16'h0000);
		// Locked write must leave every digit as it was
		wr_reg(`RTCALM_OFF_WDHR, 16'h0110);
		rd_reg("wdhr_locked", `RTCALM_OFF_WDHR, 16'h0629);
		chk("wdhr_out", alarm_time[22:14], 9'h1A9);
	endtask : t_lock

	// Unused bits read back as zero after an all-ones write
	task automatic t_unused();
		wr_reg(`RTCALM_OFF_UNLOCK, 16'h0001);
		rd_reg("unlock_rd", `RTCALM_OFF_UNLOCK, 16'h0001);
		wr_reg(`RTCALM_OFF_WDHR, 16'hFFFF);
		rd_reg("wdhr_ones", `RTCALM_OFF_WDHR, 16'h073F);
		wr_reg(`RTCALM_OFF_MINSEC, 16'hFFFF);
		rd_reg("minsec_ones", `RTCALM_OFF_MINSEC, 16'h7F7F);
		rd_reg("unmapped", 4'hF, 16'h0000);
	endtask : t_unused

	// Minutes/seconds digits, written while locked
	task automatic t_minsec();
		wr_reg(`RTCALM_OFF_UNLOCK, 16'h0000);
		wr_reg(`RTCALM_OFF_MINSEC, 16'h5948);
		chk("minute_tens", alarm_time.minute_tens, 3'h5);
		chk("minute_ones", alarm_time.minute_ones, 4'h9);
		chk("second_tens", alarm_time.second_tens, 3'h4);
		chk("second_ones", alarm_time.second_ones, 4'h8);
		rd_reg("minsec", `RTCALM_OFF_MINSEC, 16'h5948);
		// Clock enable low must freeze the stored digits
		@(posedge clock);
		ce <= 1'h0;
		wr_reg(`RTCALM_OFF_MINSEC, 16'h0000);
		// Release the enable on an edge, as every other input is driven
		@(posedge clock);
		ce <= 1'h1;
		#1 chk("frozen", alarm_time[13:0], 14'h2CC8);
	endtask : t_minsec

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		rst         = 1'h1;
		ce          = 1'h1;
		addr        = 4'h0;
		wdata       = 16'h0000;
		wr          = 1'h0;
		rd          = 1'h0;
		miscompares = 0;
		compares    = 0;
		cycles      = 0;
		repeat (3) @(posedge clock);
		rst <= 1'h0;
		t_lock();
		t_unused();
		t_minsec();
		end_of_test();
	end

endmodule : tb_top
`default_nettype wire
